//--- hw/pll_mode_and_base_clock_select.sv
// pll mode control, programming register and glitch-free base clock selector
//
// Function
// - acquisition mode shows tracking_select cleared
// - filter tracks unless in acquisition, or whenever tracking_select is set
// - automatic mode: lock detector switches acquisition and tracking by itself
// - automatic: tracking_select read-only, follows tracking/untracking tolerance
// - automatic: vco_in_tolerance read-only, follows lock/unlock tolerance
// - automatic: each lock toggle requests interrupt when synth_irq_enable is one
// - manual: tracking_select is writable and directly picks the filter mode
// - manual: lock indication disabled, no interrupt requests
// - programming register: upper nibble multiplier N, lower nibble range L
// - feedback divider divides vco clock by N
// - N of zero behaves as N of one
// - L of zero disables pll and forces crystal source
// - vco center frequency is L times 4.9152 MHz
// - source change waits three crystal edges and, while pll enabled, three vco edges; output held static
// - selected clock halved for base clock, quartered for bus clock
// - base_source_select picks source; refused while synth_power_on clear
// - clearing synth_power_on ignored while vco clock selected
// - one write cannot change both power-on and source select
// - lock_change_flag set on lock toggle, cleared by control register read
// - reset sets synth_power_on
// - reset and stop clear base_source_select
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module pll_mode_and_base_clock_select (
	input  wire logic                                core_clk,
	input  wire logic                                rst_b,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [clkgen_pkg::ADDR_W-1:0]       paddr,
	input  wire logic [clkgen_pkg::DATA_W-1:0]       pwdata,
	output logic      [clkgen_pkg::DATA_W-1:0]       prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	input  wire logic                                crystal_clock,
	input  wire logic                                vco_clock,
	input  wire logic                                lock_tol_in,
	input  wire logic                                track_tol_in,
	input  wire logic                                stop_req,
	output logic                                     base_clock_out,
	output logic                                     bus_clock_out,
	output logic                                     vco_feedback_out,
	output logic                                     pll_enable,
	output logic                                     filter_tracking,
	output logic      [clkgen_pkg::FIELD_W-1:0]      range_mult_out,
	output logic      [clkgen_pkg::CENTER_W-1:0]     vco_center_hz,
	output logic                                     synth_irq
);

	function automatic logic reg_hit(input logic [clkgen_pkg::ADDR_W-1:0] a,
	                                 input logic [9:0] idx);
		reg_hit = (a == {idx, 2'b00});
	endfunction : reg_hit

	// ---------------- input synchronisers ----------------
	logic [clkgen_pkg::NSYNC-1:0] raw_in;
	logic [clkgen_pkg::NSYNC-1:0] sy1_q;
	logic [clkgen_pkg::NSYNC-1:0] sy2_q;
	logic [clkgen_pkg::NSYNC-1:0] sy3_q;
	logic [clkgen_pkg::NSYNC-1:0] lvl_q;
	logic [clkgen_pkg::NSYNC-1:0] rise;

	assign raw_in = {track_tol_in, lock_tol_in, vco_clock, crystal_clock};

	genvar gi;
	generate
		for (gi = 0; gi < clkgen_pkg::NSYNC; gi++) begin : g_sync
			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					sy1_q[gi] <= 1'b0;
					sy2_q[gi] <= 1'b0;
					sy3_q[gi] <= 1'b0;
					lvl_q[gi] <= 1'b0;
				end else begin
					sy1_q[gi] <= raw_in[gi];
					sy2_q[gi] <= sy1_q[gi];
					sy3_q[gi] <= sy2_q[gi];
					if (sy2_q[gi] == sy3_q[gi]) begin
						lvl_q[gi] <= sy3_q[gi];
					end
				end
			end
			assign rise[gi] = (sy2_q[gi] == sy3_q[gi]) && sy3_q[gi] && !lvl_q[gi];
		end
	endgenerate

	logic xtal_rise;
	logic vco_rise;
	assign xtal_rise = rise[clkgen_pkg::SY_XTAL];
	assign vco_rise  = rise[clkgen_pkg::SY_VCO];

	// ---------------- registers ----------------
	logic       irq_en_q;
	logic       flag_q;
	logic       pwr_q;
	logic       src_q;
	logic       auto_q;
	logic       lock_q;
	logic       track_auto_q;
	logic       track_man_q;
	logic [7:0] mult_range_q;
	logic       rd_ack_q;

	logic       access;
	logic       wr_done;
	logic       rd_done;
	logic       hit_ctl;
	logic       hit_bw;
	logic       hit_mr;
	logic       mapped;
	logic [3:0] n_raw;
	logic [3:0] l_raw;
	logic [3:0] n_eff;
	logic       l_zero;
	logic       track_sel;

	assign access  = psel && penable;
	assign hit_ctl = reg_hit(paddr, clkgen_pkg::IDX_SYNTH_CTRL);
	assign hit_bw  = reg_hit(paddr, clkgen_pkg::IDX_BW_CTRL);
	assign hit_mr  = reg_hit(paddr, clkgen_pkg::IDX_MULT_RANGE);
	assign mapped  = hit_ctl || hit_bw || hit_mr;
	// a transfer completes on the edge where pready is already high
	assign wr_done = access && rd_ack_q && pwrite;
	assign rd_done = access && rd_ack_q && !pwrite;

	assign n_raw  = mult_range_q[clkgen_pkg::MULT_N_LSB +: clkgen_pkg::FIELD_W];
	assign l_raw  = mult_range_q[clkgen_pkg::RANGE_L_LSB +: clkgen_pkg::FIELD_W];
	assign n_eff  = (n_raw == clkgen_pkg::N_ZERO) ? clkgen_pkg::N_ONE : n_raw;
	assign l_zero = (l_raw == clkgen_pkg::L_ZERO);

	// automatic mode reports the detector, manual mode the written value
	assign track_sel = auto_q ? track_auto_q : track_man_q;

	// one wait state: read data is captured on the same edge that raises pready
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_ack_q <= 1'b0;
		end else begin
			rd_ack_q <= access && !rd_ack_q;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (access && !rd_ack_q) begin
			prdata  <= '0;
			pslverr <= !mapped;
			if (!pwrite && hit_ctl) begin
				prdata[clkgen_pkg::CTL_IRQ_EN_BIT] <= irq_en_q && auto_q;
				prdata[clkgen_pkg::CTL_FLAG_BIT]   <= flag_q && auto_q;
				prdata[clkgen_pkg::CTL_PWR_BIT]    <= pwr_q;
				prdata[clkgen_pkg::CTL_SRC_BIT]    <= src_q;
				prdata[3:0]                        <= clkgen_pkg::CTL_UNUSED_ONES;
			end else if (!pwrite && hit_bw) begin
				prdata[clkgen_pkg::BW_AUTO_BIT]  <= auto_q;
				prdata[clkgen_pkg::BW_LOCK_BIT]  <= lock_q && auto_q;
				prdata[clkgen_pkg::BW_TRACK_BIT] <= track_sel;
			end else if (!pwrite && hit_mr) begin
				prdata[7:0] <= mult_range_q;
			end
		end else begin
			pslverr <= 1'b0;
		end
	end

	assign pready = rd_ack_q;

	// mode bits and programming register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			auto_q       <= 1'b0;
			track_man_q  <= 1'b0;
			irq_en_q     <= 1'b0;
			mult_range_q <= clkgen_pkg::MULT_RANGE_RST;
		end else if (wr_done) begin
			if (hit_bw) begin
				auto_q <= pwdata[clkgen_pkg::BW_AUTO_BIT];
				// manual value is kept while in automatic mode
				if (!auto_q) begin
					track_man_q <= pwdata[clkgen_pkg::BW_TRACK_BIT];
				end
			end
			if (hit_ctl && auto_q) begin
				irq_en_q <= pwdata[clkgen_pkg::CTL_IRQ_EN_BIT];
			end
			if (hit_mr) begin
				mult_range_q <= pwdata[7:0];
			end
		end
	end

	// power-on and source select interlocks
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pwr_q <= 1'b1;
			src_q <= 1'b0;
		end else begin
			if (stop_req || l_zero) begin
				src_q <= 1'b0;
			end else if (wr_done && hit_ctl) begin
				if (pwdata[clkgen_pkg::CTL_PWR_BIT] != pwr_q) begin
					// a power change blocks any source change in the same write
					if (!src_q) begin
						pwr_q <= pwdata[clkgen_pkg::CTL_PWR_BIT];
					end
				end else if (pwr_q || !pwdata[clkgen_pkg::CTL_SRC_BIT]) begin
					src_q <= pwdata[clkgen_pkg::CTL_SRC_BIT];
				end
			end
		end
	end

	// lock detector status, flag and interrupt
	logic lock_in;
	logic track_in;
	assign lock_in  = lvl_q[clkgen_pkg::SY_LOCK];
	assign track_in = lvl_q[clkgen_pkg::SY_TRACK];

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lock_q       <= 1'b0;
			track_auto_q <= 1'b0;
		end else if (auto_q) begin
			lock_q       <= lock_in && pll_enable;
			track_auto_q <= track_in && pll_enable;
		end else begin
			lock_q       <= 1'b0;
			track_auto_q <= 1'b0;
		end
	end

	logic lock_toggle;
	assign lock_toggle = auto_q && ((lock_in && pll_enable) != lock_q);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_q <= 1'b0;
		end else if (lock_toggle) begin
			flag_q <= 1'b1; // set wins over read clear
		end else if (rd_done && hit_ctl) begin
			flag_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			synth_irq <= 1'b0;
		end else begin
			synth_irq <= flag_q && irq_en_q && auto_q;
		end
	end

	// ---------------- pll controls ----------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pll_enable      <= 1'b0;
			filter_tracking <= 1'b0;
			range_mult_out  <= '0;
			vco_center_hz   <= '0;
		end else begin
			pll_enable      <= pwr_q && !l_zero;
			filter_tracking <= track_sel;
			range_mult_out  <= l_raw;
			vco_center_hz   <= clkgen_pkg::CENTER_W'(l_raw)
			                   * clkgen_pkg::CENTER_W'(clkgen_pkg::NOM_CENTER_HZ);
		end
	end

	// feedback divider counts vco edges modulo N
	logic [3:0] fb_cnt_q;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			fb_cnt_q         <= '0;
			vco_feedback_out <= 1'b0;
		end else if (!pll_enable) begin
			fb_cnt_q         <= '0;
			vco_feedback_out <= 1'b0;
		end else begin
			// one-cycle pulse so each Nth vco edge is seen once downstream
			vco_feedback_out <= vco_rise && (fb_cnt_q >= n_eff - 4'h1);
			if (vco_rise) begin
				fb_cnt_q <= (fb_cnt_q >= n_eff - 4'h1) ? '0 : fb_cnt_q + 4'h1;
			end
		end
	end

	// ---------------- glitch-free source switch ----------------
	clkgen_pkg::switch_state_t sw_q;
	logic       cur_src_q;
	logic       want_src;
	logic [1:0] xcnt_q;
	logic [1:0] vcnt_q;
	logic       old_rise;
	logic       new_rise;

	assign want_src = src_q && pll_enable;
	assign old_rise = cur_src_q ? vco_rise : xtal_rise;
	assign new_rise = want_src ? vco_rise : xtal_rise;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_q      <= clkgen_pkg::SW_RUN;
			cur_src_q <= 1'b0;
			xcnt_q    <= '0;
			vcnt_q    <= '0;
		end else begin
			case (sw_q)
				clkgen_pkg::SW_RUN: begin
					xcnt_q <= '0;
					vcnt_q <= '0;
					// old gate closes on an edge of the old source, or at once while the pll is disabled
					if (want_src != cur_src_q && (old_rise || !pll_enable)) begin
						sw_q <= clkgen_pkg::SW_DRAIN;
					end
				end
				clkgen_pkg::SW_DRAIN: begin
					if (xtal_rise && xcnt_q != clkgen_pkg::SWITCH_EDGES) begin
						xcnt_q <= xcnt_q + 2'h1;
					end
					if (vco_rise && vcnt_q != clkgen_pkg::SWITCH_EDGES) begin
						vcnt_q <= vcnt_q + 2'h1;
					end
					// a vco stopped with the pll disabled cannot hold the switch forever
					if (xcnt_q == clkgen_pkg::SWITCH_EDGES
					    && (vcnt_q == clkgen_pkg::SWITCH_EDGES || !pll_enable)) begin
						sw_q <= clkgen_pkg::SW_ARM;
					end
				end
				clkgen_pkg::SW_ARM: begin
					if (new_rise) begin
						cur_src_q <= want_src;
						sw_q      <= clkgen_pkg::SW_RUN;
					end
				end
				default: begin
					sw_q <= clkgen_pkg::SW_RUN;
				end
			endcase
		end
	end

	logic cur_rise;
	assign cur_rise = cur_src_q ? vco_rise : xtal_rise;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			base_clock_out <= 1'b0;
			bus_clock_out  <= 1'b0;
		end else if (sw_q == clkgen_pkg::SW_RUN && cur_rise) begin
			base_clock_out <= !base_clock_out;
			if (!base_clock_out) begin
				bus_clock_out <= !bus_clock_out;
			end
		end
	end

endmodule : pll_mode_and_base_clock_select

//--- hw/clkgen_pkg.sv
// shared constants for the clock generator control block
package clkgen_pkg;
	localparam int unsigned ADDR_W        = 12;
	localparam int unsigned DATA_W        = 32;
	// register indices; byte address is four times the index
	localparam logic [9:0]  IDX_SYNTH_CTRL = 10'h01c;
	localparam logic [9:0]  IDX_BW_CTRL    = 10'h01d;
	localparam logic [9:0]  IDX_MULT_RANGE = 10'h01e;
	// synth_control_reg fields
	localparam int unsigned CTL_IRQ_EN_BIT  = 7;
	localparam int unsigned CTL_FLAG_BIT    = 6;
	localparam int unsigned CTL_PWR_BIT     = 5;
	localparam int unsigned CTL_SRC_BIT     = 4;
	localparam logic [3:0]  CTL_UNUSED_ONES = 4'hf;
	// bandwidth_control_reg fields
	localparam int unsigned BW_AUTO_BIT     = 7;
	localparam int unsigned BW_LOCK_BIT     = 6;
	localparam int unsigned BW_TRACK_BIT    = 5;
	// pll_multiplier_range fields
	localparam int unsigned MULT_N_LSB      = 4;
	localparam int unsigned RANGE_L_LSB     = 0;
	localparam int unsigned FIELD_W         = 4;
	localparam logic [7:0]  MULT_RANGE_RST  = 8'h66;
	localparam logic [3:0]  N_ZERO          = 4'h0;
	localparam logic [3:0]  N_ONE           = 4'h1;
	localparam logic [3:0]  L_ZERO          = 4'h0;
	// nominal vco center frequency in Hz (4.9152 MHz)
	localparam int unsigned NOM_CENTER_HZ   = 4915200;
	localparam int unsigned CENTER_W        = 27;
	// edges of each source counted during a source change
	localparam logic [1:0]  SWITCH_EDGES    = 2'h3;
	// synchronised input slots
	localparam int unsigned NSYNC           = 4;
	localparam int unsigned SY_XTAL         = 0;
	localparam int unsigned SY_VCO          = 1;
	localparam int unsigned SY_LOCK         = 2;
	localparam int unsigned SY_TRACK        = 3;
	typedef enum logic [1:0] {
		SW_RUN,
		SW_DRAIN,
		SW_ARM
	} switch_state_t;
endpackage : clkgen_pkg

//--- dv/pll_mode_and_base_clock_select_asserts.sv
// port-level checker for the pll mode and base clock selector
`timescale 1ns/1ps
module pll_mode_checker (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        lock_tol_in,
	input wire logic        base_clock_out,
	input wire logic        bus_clock_out,
	input wire logic        vco_feedback_out,
	input wire logic        pll_enable,
	input wire logic [3:0]  range_mult_out,
	input wire logic [26:0] vco_center_hz,
	input wire logic        synth_irq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	sequence ctl_read_s;
		psel && penable && pready && !pwrite && paddr == 12'h070;
	endsequence
	// lock input quiet long enough to pass the synchroniser
	sequence lock_quiet_s;
		$stable(lock_tol_in)[*8];
	endsequence
	a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
		else $error("ready not in second access cycle");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_center_tracks: assert property ($stable(range_mult_out)[*2] |->
		vco_center_hz == range_mult_out * clkgen_pkg::NOM_CENTER_HZ)
		else $error("center frequency not range times nominal");
	a_l_zero_off: assert property ((range_mult_out == 4'h0)[*2] |-> !pll_enable)
		else $error("pll enabled with zero range");
	a_bus_on_base: assert property ($changed(bus_clock_out) |-> base_clock_out)
		else $error("bus clock moved without base high");
	a_fb_pulse: assert property (vco_feedback_out |=> !vco_feedback_out)
		else $error("feedback pulse wider than one cycle");
	a_flag_read_clr: assert property (lock_quiet_s ##0 ctl_read_s ##1
		$stable(lock_tol_in)[*2] |-> !synth_irq)
		else $error("interrupt survives control read");
	a_reset_power: assert property ($rose(rst_b) |-> ##[0:2] pll_enable)
		else $error("pll not enabled after reset");
endmodule : pll_mode_checker

bind pll_mode_and_base_clock_select pll_mode_checker u_chk (.core_clk, .rst_b, .psel,
	.penable, .pwrite, .paddr, .pready, .pslverr, .lock_tol_in, .base_clock_out,
	.bus_clock_out, .vco_feedback_out, .pll_enable, .range_mult_out, .vco_center_hz,
	.synth_irq);

//--- dv/pll_mode_and_base_clock_select_bench.sv
// self-checking bench for the pll mode and base clock selector
`timescale 1ns/1ps
module pll_mode_and_base_clock_select_bench;
	localparam logic [9:0] CTL = clkgen_pkg::IDX_SYNTH_CTRL;
	localparam logic [9:0] BW  = clkgen_pkg::IDX_BW_CTRL;
	localparam logic [9:0] MR  = clkgen_pkg::IDX_MULT_RANGE;
	logic        core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic        crystal_clock = 0, vco_clock = 0, lock_tol_in = 0, track_tol_in = 0;
	logic        stop_req = 0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, base_clock_out, bus_clock_out, vco_feedback_out, er;
	logic        pll_enable, filter_tracking, synth_irq;
	logic [3:0]  range_mult_out;
	logic [26:0] vco_center_hz;
	logic [7:0]  v;
	int          fail_count = 0, total_checks = 0, cnt;
	int          ns[3] = '{0, 1, 4};

	always #5 core_clk = ~core_clk;
	// source clocks toggle on core falling edges, clear of the rising edges
	always #40 crystal_clock = ~crystal_clock;
	always #30 vco_clock = ~vco_clock;

	pll_mode_and_base_clock_select dut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .crystal_clock, .vco_clock, .lock_tol_in,
		.track_tol_in, .stop_req, .base_clock_out, .bus_clock_out, .vco_feedback_out,
		.pll_enable, .filter_tracking, .range_mult_out, .vco_center_hz, .synth_irq);

	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	function logic near(input int got, input int exp);
		return got >= exp - 1 && got <= exp + 1;
	endfunction : near

	// source rises seen in a window, divided down
	function int edges(input int cycles, input int half_ns, input int div);
		return cycles * 10 / (2 * half_ns) / div;
	endfunction : edges

	task apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k >= 16) begin
			fail_count++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rchk(input logic [9:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 8'h00);
		check(rd, {24'h0, e});
	endtask : rchk

	// settle first: a source switch can take tens of core cycles
	task measure(input logic sel, input int cycles);
		logic p;
		repeat (60) @(posedge core_clk);
		cnt = 0;
		p = base_clock_out;
		repeat (cycles) begin
			@(posedge core_clk);
			if (sel ? base_clock_out !== p : vco_feedback_out === 1'b1)
				cnt++;
			p = base_clock_out;
		end
	endtask : measure

	initial begin
		void'($urandom(32'hca13_1afa));
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		rchk(CTL, 8'h2f);
		rchk(BW, 8'h00);
		rchk(MR, clkgen_pkg::MULT_RANGE_RST);
		apb(1'b0, 10'h01f, 8'h00);
		check(er, 1'b1);
		for (int i = 0; i < 8; i++) begin
			v = {4'($urandom_range(15)), 4'($urandom_range(15, 1))};
			apb(1'b1, MR, v);
			rchk(MR, v);
			check(range_mult_out, v[3:0]);
			check(vco_center_hz, v[3:0] * clkgen_pkg::NOM_CENTER_HZ);
		end
		foreach (ns[i]) begin
			apb(1'b1, MR, {4'(ns[i]), 4'h6});
			measure(1'b0, 240);
			check(near(cnt, edges(240, 30, ns[i] == 0 ? 1 : ns[i])), 1'b1);
		end
		apb(1'b1, CTL, 8'h10);
		rchk(CTL, 8'h0f);
		apb(1'b1, CTL, 8'h10);
		rchk(CTL, 8'h0f);
		measure(1'b1, 240);
		check(near(cnt, edges(240, 40, 1)), 1'b1);
		apb(1'b1, CTL, 8'h20);
		apb(1'b1, CTL, 8'h30);
		rchk(CTL, 8'h3f);
		measure(1'b1, 240);
		check(near(cnt, edges(240, 30, 1)), 1'b1);
		apb(1'b1, CTL, 8'h10);
		rchk(CTL, 8'h3f);
		@(posedge core_clk);
		stop_req <= 1'b1;
		rchk(CTL, 8'h2f);
		stop_req <= 1'b0;
		apb(1'b1, BW, 8'h80);
		apb(1'b1, CTL, 8'ha0);
		lock_tol_in <= 1'b1;
		track_tol_in <= 1'b1;
		repeat (10) @(posedge core_clk);
		check(synth_irq, 1'b1);
		check(filter_tracking, 1'b1);
		rchk(BW, 8'he0);
		rchk(CTL, 8'hef);
		rchk(CTL, 8'haf);
		check(synth_irq, 1'b0);
		lock_tol_in <= 1'b0;
		track_tol_in <= 1'b0;
		repeat (10) @(posedge core_clk);
		check(filter_tracking, 1'b0);
		rchk(BW, 8'h80);
		rchk(CTL, 8'hef);
		apb(1'b1, BW, 8'h00);
		// tracking_select is only writable once auto is already clear
		apb(1'b1, BW, 8'h20);
		rchk(BW, 8'h20);
		check(filter_tracking, 1'b1);
		lock_tol_in <= 1'b1;
		repeat (10) @(posedge core_clk);
		check(synth_irq, 1'b0);
		apb(1'b1, CTL, 8'ha0);
		rchk(CTL, 8'h2f);
		apb(1'b1, CTL, 8'h30);
		apb(1'b1, MR, 8'h40);
		repeat (3) @(posedge core_clk);
		check(pll_enable, 1'b0);
		rchk(CTL, 8'h2f);
		stop_test();
	end
endmodule : pll_mode_and_base_clock_select_bench
